/* File: pcg_chk.sv */
// concurrent checks on the port latch and pin mode block ports
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"

module pcg_chk import pcg_pkg::*; #(
  parameter int NUM_PORTS = 5
) (
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  // register access
  input wire logic [7:0]             i_sfr_addr,
  input wire logic                   i_sfr_wr,
  input wire pcg_byte_t              i_sfr_wdata,
  input wire logic                   i_sfr_bit_wr,
  input wire logic [2:0]             i_sfr_bit_sel,
  input wire logic                   i_sfr_bit_val,
  input wire logic                   i_sfr_rd,
  input wire logic                   i_sfr_rmw,
  input wire pcg_byte_t              o_sfr_rdata,
  // pins
  input wire logic [8*NUM_PORTS-1:0] i_pin_in,
  input wire logic [8*NUM_PORTS-1:0] o_pin_out,
  input wire logic [8*NUM_PORTS-1:0] o_pin_oe,
  input wire logic [8*NUM_PORTS-1:0] o_pin_pullup_en,
  input wire logic [7:0]             o_p3_analog
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wire logic at_p0 = i_sfr_addr == `PCG_ADDR_PORT0;
  wire logic p0_any = (i_sfr_wr || i_sfr_bit_wr) && at_p0;
  wire logic any_wr = i_sfr_wr || i_sfr_bit_wr;

  property p_pullup;
    &o_pin_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable dropped");
  property p_rst_state;
    $rose(i_rst_n) |-> o_pin_oe == '0 && &o_pin_out
                       && o_sfr_rdata == 8'h00;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("pins not in reset state");
  property p_byte_wr;
    i_sfr_wr && at_p0 ##1 !p0_any |=>
      o_pin_oe[7:0] == ~$past(i_sfr_wdata, 2);
  endproperty
  a_byte_wr: assert property (p_byte_wr)
    else $error("port 0 pins miss byte write");
  property p_bit_wr;
    i_sfr_bit_wr && !i_sfr_wr && at_p0 ##1 !p0_any |=>
      o_pin_oe[$past(i_sfr_bit_sel, 2)] == !$past(i_sfr_bit_val, 2);
  endproperty
  a_bit_wr: assert property (p_bit_wr)
    else $error("port 0 pin misses bit write");
  property p_p4_bit;
    !i_sfr_wr ##1 (!i_sfr_wr && i_sfr_bit_wr
                   && i_sfr_addr == `PCG_ADDR_PORT4)
      |=> $stable(o_pin_oe[39:32]) [*2];
  endproperty
  a_p4_bit: assert property (p_p4_bit)
    else $error("port 4 took a bit write");
  property p_pin_rd;
    i_sfr_rd && !i_sfr_rmw && i_sfr_addr == `PCG_ADDR_PORT1
      && $stable(i_pin_in[15:8])
      && i_pin_in[15:8] == $past(i_pin_in[15:8], 2)
      |=> o_sfr_rdata == $past(i_pin_in[15:8]);
  endproperty
  a_pin_rd: assert property (p_pin_rd)
    else $error("port read not from pins");
  property p_rmw_rd;
    i_sfr_rd && i_sfr_rmw && i_sfr_addr == `PCG_ADDR_PORT2
      && !$past(any_wr) |=> o_sfr_rdata == ~$past(o_pin_oe[23:16]);
  endproperty
  a_rmw_rd: assert property (p_rmw_rd)
    else $error("modify read not from latch");
  property p_analog;
    $stable(o_p3_analog) |-> (o_p3_analog & o_pin_oe[31:24]) == 8'h00;
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog pin driven");
  property p_hold;
    !any_wr [*2] |=> $stable(o_pin_oe[15:8]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("port 1 pins moved without write");
endmodule : pcg_chk

bind pcg_top pcg_chk #(.NUM_PORTS(NUM_PORTS)) pcg_chk_inst (
  .i_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
  .i_sfr_bit_wr, .i_sfr_bit_sel, .i_sfr_bit_val, .i_sfr_rd,
  .i_sfr_rmw, .o_sfr_rdata, .i_pin_in, .o_pin_out, .o_pin_oe,
  .o_pin_pullup_en, .o_p3_analog
);

`default_nettype wire

/* File: pcg_crossbar.sv */
// priority crossbar decoder that places routed signals on port 3 pins
`timescale 1ns/1ps
`default_nettype none

module pcg_crossbar (
  // configuration
  input  wire logic            i_uart_en,
  input  wire logic            i_smb_en,
  input  wire pcg_pkg::pcg_byte_t i_skip,
  // one-hot pin selections
  output logic [7:0]           o_sel_tx,
  output logic [7:0]           o_sel_rx,
  output logic [7:0]           o_sel_sda,
  output logic [7:0]           o_sel_scl
);
  import pcg_pkg::*;

  pcg_sig_t   queue [4];
  logic [2:0] need;
  logic [2:0] used;

  always_comb begin
    queue[0] = PCG_SIG_NONE;
    queue[1] = PCG_SIG_NONE;
    queue[2] = PCG_SIG_NONE;
    queue[3] = PCG_SIG_NONE;
    need     = 3'h0;
    used     = 3'h0;
    o_sel_tx  = 8'h00;
    o_sel_rx  = 8'h00;
    o_sel_sda = 8'h00;
    o_sel_scl = 8'h00;
    // uart ranks above smbus in the assignment order
    if (i_uart_en) begin
      queue[0] = PCG_SIG_TX;
      queue[1] = PCG_SIG_RX;
      need     = 3'h2;
    end
    if (i_smb_en) begin
      queue[need[1:0]]        = PCG_SIG_SDA;
      queue[need[1:0] + 2'h1] = PCG_SIG_SCL;
      need                    = need + 3'h2;
    end
    for (int i = 0; i < 8; i++) begin
      if (!i_skip[i] && (used < need)) begin
        unique case (queue[used[1:0]])
          PCG_SIG_TX:  o_sel_tx[i]  = 1'b1;
          PCG_SIG_RX:  o_sel_rx[i]  = 1'b1;
          PCG_SIG_SDA: o_sel_sda[i] = 1'b1;
          PCG_SIG_SCL: o_sel_scl[i] = 1'b1;
          PCG_SIG_NONE: ;
        endcase
        used = used + 3'h1;
      end
    end
  end

endmodule : pcg_crossbar

`default_nettype wire

/* File: pcg_defines.svh */
// constants of the port latch, pin mode and crossbar register block
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PCG_ADDR_PORT0          8'h80
`define PCG_ADDR_PORT1          8'h90
`define PCG_ADDR_PORT2          8'hA0
`define PCG_ADDR_PORT3          8'hB0
`define PCG_ADDR_PORT4          8'hC7
`define PCG_ADDR_P3_OUT_MODE    8'hA7
`define PCG_ADDR_P3_IN_MODE     8'hF4
`define PCG_ADDR_P3_SKIP        8'hDF
`define PCG_ADDR_XBAR_TWO       8'hE3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCG_RST_LATCH           8'hFF
`define PCG_RST_P3_OUT_MODE     8'h00
`define PCG_RST_P3_IN_MODE      8'hFF
`define PCG_RST_P3_SKIP         8'h00
`define PCG_RST_XBAR_TWO        2'h0
`define PCG_RST_READ_DATA       8'h00

// ----------------------------------------------------------------
// field positions and sizes
// ----------------------------------------------------------------
`define PCG_XBAR_UART_BIT       0
`define PCG_XBAR_SMB_BIT        1
`define PCG_XBAR_USED_BITS      2
`define PCG_XBAR_PAD            6'h00
`define PCG_BYTE_W              8
`define PCG_BIT_PORTS           4
`define PCG_PORT3_IDX           3
`define PCG_UNMAPPED_READ       8'h00

`endif

/* File: pcg_pin_model.sv */
// package pin model: resolves drive, pull-up and external pull-down
`timescale 1ns/1ps
`default_nettype none

module pcg_pin_model #(
  parameter int W = 40
) (
  // from the block
  input  wire logic [W-1:0] i_pin_out,
  input  wire logic [W-1:0] i_pin_oe,
  input  wire logic [W-1:0] i_pullup_en,
  // from the board
  input  wire logic [W-1:0] i_ext_low,
  // to the block
  output logic [W-1:0]      o_pin_in
);
  // a released pin rises through the weak pull-up unless held low outside; with none it
  // shows the inverse of the last drive so a stale value cannot pass
  assign o_pin_in = (i_pin_oe & i_pin_out)
                  | (~i_pin_oe & ~i_ext_low
                     & (i_pullup_en | ~i_pin_out));
endmodule : pcg_pin_model

`default_nettype wire

/* File: pcg_pkg.sv */
// shared types of the port latch, pin mode and crossbar block
package pcg_pkg;

  // peripheral signals the crossbar can place on a port 3 pin
  typedef enum logic [2:0] {
    PCG_SIG_NONE,
    PCG_SIG_TX,
    PCG_SIG_RX,
    PCG_SIG_SDA,
    PCG_SIG_SCL
  } pcg_sig_t;

  typedef logic [7:0] pcg_byte_t;

endpackage : pcg_pkg

/* File: pcg_top.sv */
// port latches, pin readback, port 3 pin modes and crossbar routing
//
// Contract
// - a port write is latched and keeps driving the pins until rewritten.
// - an ordinary port read returns the synchronised pin levels.
// - read-modify-write reads return the output latch instead of the pins.
// - ports 3..0 take byte and bit writes; port 4 takes bytes only.
// - port 3 output mode bit selects open-drain (0) or push-pull (1).
// - an analog port 3 pin (input mode 0) ignores its output mode bit.
// - a set port 3 skip bit makes the crossbar pass over that pin.
// - crossbar bit 1 routes the second smbus to pins, else none.
// - crossbar bit 0 routes second uart transmit and receive to pins.
// - reset loads all port latches with ones, outputs open-drain.
// - weak pull-ups stay enabled during and after reset.
// - unassigned digital pins act as plain I/O from their latch.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"

module pcg_top #(
  parameter int NUM_PORTS = 5
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // special function register access
  input  wire logic [7:0]           i_sfr_addr,
  input  wire logic                 i_sfr_wr,
  input  wire pcg_pkg::pcg_byte_t   i_sfr_wdata,
  input  wire logic                 i_sfr_bit_wr,
  input  wire logic [2:0]           i_sfr_bit_sel,
  input  wire logic                 i_sfr_bit_val,
  input  wire logic                 i_sfr_rd,
  input  wire logic                 i_sfr_rmw,
  output pcg_pkg::pcg_byte_t        o_sfr_rdata,
  // package pins, port n in bits 8n+7..8n
  input  wire logic [8*NUM_PORTS-1:0] i_pin_in,
  output logic [8*NUM_PORTS-1:0]    o_pin_out,
  output logic [8*NUM_PORTS-1:0]    o_pin_oe,
  output logic [8*NUM_PORTS-1:0]    o_pin_pullup_en,
  output logic [7:0]                o_p3_analog,
  // second uart
  input  wire logic                 i_uart_tx,
  output logic                      o_uart_rx,
  // second smbus, a 1 releases the line
  input  wire logic                 i_smb_sda_out,
  input  wire logic                 i_smb_scl_out,
  output logic                      o_smb_sda_in,
  output logic                      o_smb_scl_in
);
  import pcg_pkg::*;

  localparam int BW = `PCG_BYTE_W;
  localparam int PW = BW * NUM_PORTS;

  // only ports 0..4 have addresses, and port 3 is always needed
  if (NUM_PORTS < 4 || NUM_PORTS > 5) begin : g_bad_ports
    $error("pcg_top: NUM_PORTS must be 4 or 5");
  end

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic          rst_meta_reg;
  logic          rst_sync_reg;
  logic          rst_n;
  logic [PW-1:0] pin_meta_reg;
  logic [PW-1:0] pin_sync_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // pins change outside the clock, so nothing reads the first stage
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '1;
      pin_sync_reg <= '1;
    end else begin
      pin_meta_reg <= i_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [7:0] port_addr [5];
  logic [4:0] hit_port;
  logic       hit_out_mode;
  logic       hit_in_mode;
  logic       hit_skip;
  logic       hit_xbar;

  assign port_addr[0]  = `PCG_ADDR_PORT0;
  assign port_addr[1]  = `PCG_ADDR_PORT1;
  assign port_addr[2]  = `PCG_ADDR_PORT2;
  assign port_addr[3]  = `PCG_ADDR_PORT3;
  assign port_addr[4]  = `PCG_ADDR_PORT4;
  assign hit_out_mode  = (i_sfr_addr == `PCG_ADDR_P3_OUT_MODE);
  assign hit_in_mode   = (i_sfr_addr == `PCG_ADDR_P3_IN_MODE);
  assign hit_skip      = (i_sfr_addr == `PCG_ADDR_P3_SKIP);
  assign hit_xbar      = (i_sfr_addr == `PCG_ADDR_XBAR_TWO);

  // ----------------------------------------------------------------
  // port output latches
  // ----------------------------------------------------------------
  logic [PW-1:0] latch_reg;
  logic [PW-1:0] latch_next;

  for (genvar p = 0; p < 5; p++) begin : g_decode
    if (p < NUM_PORTS) begin : g_live
      assign hit_port[p] = (i_sfr_addr == port_addr[p]);
    end else begin : g_none
      assign hit_port[p] = 1'b0;
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_latch
    logic        byte_we;
    logic        bit_we;
    logic [BW-1:0] bit_mask;
    logic [BW-1:0] bit_data;
    assign byte_we  = i_sfr_wr && hit_port[p];
    // bit writes reach only the bit-addressable ports
    assign bit_we   = i_sfr_bit_wr && hit_port[p]
                      && (p < `PCG_BIT_PORTS);
    assign bit_mask = BW'(1) << i_sfr_bit_sel;
    assign bit_data = i_sfr_bit_val ? (latch_reg[p*BW +: BW] | bit_mask)
                                    : (latch_reg[p*BW +: BW] & ~bit_mask);
    assign latch_next[p*BW +: BW] =
      byte_we ? i_sfr_wdata :
      bit_we  ? bit_data    :
                latch_reg[p*BW +: BW];
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= {NUM_PORTS{`PCG_RST_LATCH}};
    end else begin
      latch_reg <= latch_next;
    end
  end

  // ----------------------------------------------------------------
  // port 3 mode, skip and crossbar registers
  // ----------------------------------------------------------------
  pcg_byte_t                     out_mode_reg;
  pcg_byte_t                     in_mode_reg;
  pcg_byte_t                     skip_reg;
  logic [`PCG_XBAR_USED_BITS-1:0] xbar_reg;

  // reserved crossbar bits are not stored and read back as zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_mode_reg <= `PCG_RST_P3_OUT_MODE;
      in_mode_reg  <= `PCG_RST_P3_IN_MODE;
      skip_reg     <= `PCG_RST_P3_SKIP;
      xbar_reg     <= `PCG_RST_XBAR_TWO;
    end else if (i_sfr_wr) begin
      if (hit_out_mode) out_mode_reg <= i_sfr_wdata;
      if (hit_in_mode)  in_mode_reg  <= i_sfr_wdata;
      if (hit_skip)     skip_reg     <= i_sfr_wdata;
      if (hit_xbar)     xbar_reg     <= i_sfr_wdata[`PCG_XBAR_USED_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [PW-1:0] port_view;
  pcg_byte_t     rd_mux;
  pcg_byte_t     rdata_reg;

  // the latch for read-modify-write, the pins otherwise
  assign port_view = i_sfr_rmw ? latch_reg : pin_sync_reg;

  always_comb begin
    rd_mux = `PCG_UNMAPPED_READ;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (hit_port[p]) rd_mux = port_view[p*BW +: BW];
    end
    if (hit_out_mode) rd_mux = out_mode_reg;
    if (hit_in_mode)  rd_mux = in_mode_reg;
    if (hit_skip)     rd_mux = skip_reg;
    if (hit_xbar)     rd_mux = {`PCG_XBAR_PAD, xbar_reg};
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `PCG_RST_READ_DATA;
    end else if (i_sfr_rd) begin
      rdata_reg <= rd_mux;
    end
  end
  assign o_sfr_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // crossbar assignment on port 3
  // ----------------------------------------------------------------
  logic [7:0] sel_tx;
  logic [7:0] sel_rx;
  logic [7:0] sel_sda;
  logic [7:0] sel_scl;

  pcg_crossbar u_crossbar (
    .i_uart_en (xbar_reg[`PCG_XBAR_UART_BIT]),
    .i_smb_en  (xbar_reg[`PCG_XBAR_SMB_BIT]),
    .i_skip    (skip_reg),
    .o_sel_tx  (sel_tx),
    .o_sel_rx  (sel_rx),
    .o_sel_sda (sel_sda),
    .o_sel_scl (sel_scl)
  );

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [PW-1:0] drv_val;
  logic [PW-1:0] drv_oe;
  logic [7:0]    p3_latch;
  logic [7:0]    p3_pins;
  logic [7:0]    p3_val;
  logic [7:0]    p3_oe;
  logic [7:0]    p3_od;

  assign p3_latch = latch_reg[`PCG_PORT3_IDX*BW +: BW];
  assign p3_pins  = pin_sync_reg[`PCG_PORT3_IDX*BW +: BW];

  // peripheral data replaces the latch, which is left untouched
  assign p3_val = (sel_tx  & {8{i_uart_tx}})
                | (sel_sda & {8{i_smb_sda_out}})
                | (sel_scl & {8{i_smb_scl_out}})
                | sel_rx
                | (~(sel_tx | sel_sda | sel_scl | sel_rx) & p3_latch);
  // smbus lines are always open-drain; receive pins never drive
  assign p3_od  = ~out_mode_reg | sel_sda | sel_scl;
  assign p3_oe  = in_mode_reg & ~sel_rx
                & (~p3_od | ~p3_val);

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_drive
    if (p == `PCG_PORT3_IDX) begin : g_p3
      assign drv_val[p*BW +: BW] = p3_val;
      assign drv_oe[p*BW +: BW]  = p3_oe;
    end else begin : g_od
      // other ports stay open-drain: only a zero is driven
      assign drv_val[p*BW +: BW] = latch_reg[p*BW +: BW];
      assign drv_oe[p*BW +: BW]  = ~latch_reg[p*BW +: BW];
    end
  end

  // ----------------------------------------------------------------
  // pin and peripheral output flops
  // ----------------------------------------------------------------
  logic        rx_next;
  logic        sda_next;
  logic        scl_next;
  logic [PW-1:0] pullup_reg;

  // an unrouted input sees an idle high line
  assign rx_next  = ~|sel_rx  | |(sel_rx  & p3_pins);
  assign sda_next = ~|sel_sda | |(sel_sda & p3_pins);
  assign scl_next = ~|sel_scl | |(sel_scl & p3_pins);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pin_out    <= {NUM_PORTS{`PCG_RST_LATCH}};
      o_pin_oe     <= '0;
      o_uart_rx    <= 1'b1;
      o_smb_sda_in <= 1'b1;
      o_smb_scl_in <= 1'b1;
    end else begin
      o_pin_out    <= drv_val;
      o_pin_oe     <= drv_oe;
      o_uart_rx    <= rx_next;
      o_smb_sda_in <= sda_next;
      o_smb_scl_in <= scl_next;
    end
  end

  // pull-ups never switch off, so the reset value is the run value
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_reg <= '1;
    end else begin
      pullup_reg <= '1;
    end
  end
  assign o_pin_pullup_en = pullup_reg | {PW{~rst_n}};
  assign o_p3_analog     = ~in_mode_reg;

endmodule : pcg_top

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the port latch, pin mode and crossbar block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"

module testbench;
  import pcg_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, bwr = 1'b0;
  logic        bval = 1'b0, rd = 1'b0, rmw = 1'b0, tx = 1'b1;
  logic        sda_o = 1'b1, scl_o = 1'b1, rx, sda_i, scl_i;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, analog;
  logic [2:0]  bsel = 3'h0;
  pcg_byte_t   rdata;
  logic [39:0] pin_in, pin_out, pin_oe, pull, ext_low = 40'h0;
  int          errors = 0, total_checks = 0;
  // address, data written, value read back
  logic [23:0] rows [7] = '{24'hA75A5A, 24'hDFC3C3, 24'hE3FF03,
    24'hF4FFFF, 24'hC73C3C, 24'h80A5A5, 24'h817700};
  logic [15:0] rv [8] = '{16'h80FF, 16'h90FF, 16'hA0FF, 16'hB0FF,
    16'hC7FF, 16'hA700, 16'hDF00, 16'hE300};

  always #12.5 clk = ~clk;

  pcg_top pcg_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_bit_wr(bwr),
    .i_sfr_bit_sel(bsel), .i_sfr_bit_val(bval), .i_sfr_rd(rd),
    .i_sfr_rmw(rmw), .o_sfr_rdata(rdata), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_pullup_en(pull),
    .o_p3_analog(analog), .i_uart_tx(tx), .o_uart_rx(rx),
    .i_smb_sda_out(sda_o), .i_smb_scl_out(scl_o),
    .o_smb_sda_in(sda_i), .o_smb_scl_in(scl_i));
  pcg_pin_model pcg_pin_model_inst (.i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .i_pullup_en(pull), .i_ext_low(ext_low),
    .o_pin_in(pin_in));

  // ----------------------------------------------------------------
  // bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic bitw(input logic [7:0] a, input logic [2:0] s,
                      input logic v);
    @(posedge clk);
    addr <= a;
    bsel <= s;
    bval <= v;
    bwr  <= 1'b1;
    @(posedge clk);
    bwr <= 1'b0;
  endtask : bitw
  task automatic rchk(input logic [7:0] a, input logic m,
                      input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rmw  <= m;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({32'h0, rdata}, {32'h0, e});
  endtask : rchk
  task automatic set_ext(input logic [39:0] v);
    @(posedge clk);
    ext_low <= v;
  endtask : set_ext
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    check(pull, {40{1'b1}});
    check(pin_out, {40{1'b1}});
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wreg(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], 1'b1, rows[i][7:0]);
    end
    // a second reset in mid-run must clear what the rows left behind
    do_reset();
    check(pin_oe, 40'h0);
    foreach (rv[i]) rchk(rv[i][15:8], 1'b1, rv[i][7:0]);
    set_ext(40'h100);
    tick(3);
    rchk(`PCG_ADDR_PORT1, 1'b0, 8'hFE);
    rchk(`PCG_ADDR_PORT1, 1'b1, 8'hFF);
    set_ext(40'h0);
    bitw(`PCG_ADDR_PORT0, 3'h5, 1'b0);
    bitw(`PCG_ADDR_PORT3, 3'h2, 1'b0);
    bitw(`PCG_ADDR_PORT4, 3'h0, 1'b0);
    tick(3);
    check(40'({pin_oe[5], pin_oe[26], pin_out[26]}), 40'h6);
    rchk(`PCG_ADDR_PORT4, 1'b1, 8'hFF);
    wreg(`PCG_ADDR_P3_OUT_MODE, 8'h08);
    tick(3);
    check(40'({pin_oe[27], pin_out[27]}), 40'h3);
    wreg(`PCG_ADDR_P3_IN_MODE, 8'hF7);
    tick(3);
    check(40'({analog[3], pin_oe[27]}), 40'h2);
    wreg(`PCG_ADDR_P3_IN_MODE, 8'hFF);
    wreg(`PCG_ADDR_PORT3, 8'hFF);
    @(posedge clk);
    tx <= 1'b0;
    wreg(`PCG_ADDR_XBAR_TWO, 8'h01);
    set_ext(40'h1 << 25);
    tick(4);
    check(40'({pin_oe[24], pin_out[24], rx}), 40'h4);
    rchk(`PCG_ADDR_PORT3, 1'b1, 8'hFF);
    wreg(`PCG_ADDR_P3_SKIP, 8'h01);
    set_ext(40'h1 << 26);
    tick(4);
    check(40'({pin_oe[25:24], rx}), 40'h4);
    wreg(`PCG_ADDR_XBAR_TWO, 8'h03);
    @(posedge clk);
    sda_o <= 1'b0;
    tick(3);
    check(40'({pin_oe[27], pin_out[27]}), 40'h2);
    @(posedge clk);
    sda_o <= 1'b1;
    set_ext(40'h1 << 28);
    tick(4);
    check(40'({pin_oe[27], scl_i}), 40'h0);
    wreg(`PCG_ADDR_XBAR_TWO, 8'h01);
    tick(4);
    check(40'({scl_i, sda_i, pin_oe[27], pin_out[27]}), 40'hF);
    wreg(`PCG_ADDR_XBAR_TWO, 8'h00);
    tick(4);
    check(40'({rx, pin_oe[25]}), 40'h2);
    results();
  end

  initial begin
    #200us;
    errors++;
    results();
  end
endmodule : testbench

`default_nettype wire
